// ==== pin_ctrl_defines.svh ====
// Timing counts, field positions and strap format codes of the pin control block
`ifndef PIN_CTRL_DEFINES_SVH
`define PIN_CTRL_DEFINES_SVH
`define Q_WIDTH            10
`define Q_MIN              10'h002
`define REF_DIV_COUNT      9'h12c
`define REF_DIV_LAST       9'h12b
`define TB_WIDTH           33
`define TB_UPPER_WIDTH     24
`define TB_LOWER_WIDTH     9
`define TB_MAX             33'h1ffffffff
`define EDGE_IRQ_NUMBER    2'h3
`define FMT_I2C            1'b1
`define FMT_SPI            1'b0
`endif

// ==== pin_ctrl_pkg.sv ====
// Types shared by the pin control block
package pin_ctrl_pkg;
   typedef enum logic [1:0] {st_reset, st_boot, st_run} boot_state_t;
   typedef struct packed {
      logic       timebase_enable;
      logic       counter_clock_select;
      logic       external_flag;
      logic [9:0] q_divisor;
   } clock_manager_ctrl0_t;
   typedef struct packed {
      logic direction;
      logic output_level_bit;
      logic edge_irq_enable;
   } long_interrupt_register_t;
endpackage : pin_ctrl_pkg

// ==== sync_edge.sv ====
// Two-stage synchroniser with rising-edge detect
`timescale 1ns/1ps
module sync_edge
(
   input  wire logic clock,
   input  wire logic nrst,
   input  wire logic async_in,
   output logic      level,
   output logic      rise
);
   logic meta_r;
   logic sync_r;
   logic prev_r;
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         meta_r <= 1'b0;
         sync_r <= 1'b0;
         prev_r <= 1'b0;
      end
      else
      begin
         meta_r <= async_in;
         sync_r <= meta_r;
         prev_r <= sync_r;
      end
   end
   assign level = sync_r;
   assign rise  = sync_r & ~prev_r;
endmodule : sync_edge

// ==== pin_timebase_control.sv ====
// Pin, timebase and boot control logic of the decoder DSP
`timescale 1ns/1ps
`include "pin_ctrl_defines.svh"
module pin_timebase_control
(
   input  wire logic                                   clock,
   input  wire logic                                   nrst,
   input  wire pin_ctrl_pkg::clock_manager_ctrl0_t     cm0_wdata,
   input  wire logic                                   cm0_write,
   input  wire pin_ctrl_pkg::long_interrupt_register_t long_interrupt_register_wdata,
   input  wire logic                                   long_interrupt_register_write,
   input  wire logic                                   outbox_write,
   input  wire logic                                   host_service_done,
   input  wire logic                                   format_wdata,
   input  wire logic                                   format_write,
   input  wire logic                                   boot_pin,
   input  wire logic                                   chip_select_n,
   input  wire logic                                   counter_clock_90k,
   input  wire logic                                   reference_tick,
   input  wire logic                                   external_vco_select,
   input  wire logic                                   user_io_in,
   output logic                                        user_io_out,
   output logic                                        user_io_oe,
   output logic                                        external_flag_out,
   output logic                                        external_flag_oe,
   output logic                                        divided_clock_output,
   output logic                                        host_attention_n,
   output logic                                        port_format_select,
   output logic                                        port_enable,
   output logic                                        alt_clock_enable,
   output logic                                        dac_mute,
   output logic                                        dac_recalibrate,
   output logic                                        boot_loader_start,
   output logic                                        input_level_bit,
   output logic                                        irq3_pulse,
   output logic [`TB_UPPER_WIDTH-1:0]                  timebase_upper,
   output logic [`TB_LOWER_WIDTH-1:0]                  timebase_lower
);
   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   pin_ctrl_pkg::clock_manager_ctrl0_t     clock_manager_ctrl0_r;
   pin_ctrl_pkg::long_interrupt_register_t long_interrupt_register_r;
   pin_ctrl_pkg::boot_state_t              state_r;
   logic [`Q_WIDTH-1:0]   qcnt_r;
   logic [`Q_WIDTH-1:0]   q_eff;
   logic [8:0]            refdiv_r;
   logic                  ref_tick;
   logic                  tb_tick;
   logic [`TB_WIDTH-1:0]  timebase_r;
   logic [`TB_WIDTH-1:0]  timebase_nxt;
   logic                  io_level;
   logic                  io_rise;
   logic                  c90_rise;
   logic                  fmt_captured_r;

   // ------------------------------------------------------------
   // Input synchronisers
   // ------------------------------------------------------------
   sync_edge u_sync_io
   (
      .clock    (clock),
      .nrst     (nrst),
      .async_in (user_io_in),
      .level    (io_level),
      .rise     (io_rise)
   );
   sync_edge u_sync_90k
   (
      .clock    (clock),
      .nrst     (nrst),
      .async_in (counter_clock_90k),
      .level    (),
      .rise     (c90_rise)
   );

   // ------------------------------------------------------------
   // Control registers
   // ------------------------------------------------------------
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
         clock_manager_ctrl0_r <= '0;
      else if (cm0_write)
         clock_manager_ctrl0_r <= cm0_wdata;
   end

   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
         long_interrupt_register_r <= '0;
      else if (long_interrupt_register_write)
         long_interrupt_register_r <= long_interrupt_register_wdata;
   end

   // ------------------------------------------------------------
   // Reset, boot and format strap
   // ------------------------------------------------------------
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         state_r           <= pin_ctrl_pkg::st_reset;
         dac_mute          <= 1'b1;
         port_enable       <= 1'b0;
         dac_recalibrate   <= 1'b0;
         boot_loader_start <= 1'b0;
      end
      else
      begin
         dac_recalibrate   <= 1'b0;
         boot_loader_start <= 1'b0;
         unique case (state_r)
            pin_ctrl_pkg::st_reset:
            begin
               dac_mute        <= 1'b0;
               port_enable     <= 1'b1;
               dac_recalibrate <= 1'b1;
               if (boot_pin)
               begin
                  boot_loader_start <= 1'b1;
                  state_r           <= pin_ctrl_pkg::st_boot;
               end
               else
                  state_r <= pin_ctrl_pkg::st_run;
            end
            pin_ctrl_pkg::st_boot:
               state_r <= pin_ctrl_pkg::st_run;
            pin_ctrl_pkg::st_run:
               state_r <= pin_ctrl_pkg::st_run;
         endcase
      end
   end

   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         fmt_captured_r     <= 1'b0;
         port_format_select <= 1'b0;
      end
      else if (!fmt_captured_r)
      begin
         fmt_captured_r     <= 1'b1;
         port_format_select <= chip_select_n ? `FMT_I2C : `FMT_SPI;
      end
      else if (format_write)
         port_format_select <= format_wdata;
   end

   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
         alt_clock_enable <= 1'b0;
      else
         alt_clock_enable <= external_vco_select;
   end

   // ------------------------------------------------------------
   // Host attention
   // ------------------------------------------------------------
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
         host_attention_n <= 1'b1;
      else if (outbox_write)
         host_attention_n <= 1'b0;
      else if (host_service_done)
         host_attention_n <= 1'b1;
   end

   // ------------------------------------------------------------
   // Divided clock output
   // ------------------------------------------------------------
   assign q_eff = (clock_manager_ctrl0_r.q_divisor < `Q_MIN) ?
                  `Q_MIN : clock_manager_ctrl0_r.q_divisor;

   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         qcnt_r               <= '0;
         divided_clock_output <= 1'b0;
      end
      else if (qcnt_r >= q_eff - 10'h001)
      begin
         qcnt_r               <= '0;
         divided_clock_output <= ~divided_clock_output;
      end
      else
         qcnt_r <= qcnt_r + 10'h001;
   end

   // ------------------------------------------------------------
   // Timebase
   // ------------------------------------------------------------
   assign ref_tick = reference_tick && (refdiv_r == `REF_DIV_LAST);

   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
         refdiv_r <= '0;
      else if (reference_tick)
         refdiv_r <= ref_tick ? 9'h000 : refdiv_r + 9'h001;
   end

   assign tb_tick = clock_manager_ctrl0_r.counter_clock_select ?
                    ref_tick : c90_rise;
   assign timebase_nxt = (timebase_r == `TB_MAX) ?
                         '0 : timebase_r + 33'h000000001;

   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
         timebase_r <= '0;
      else if (clock_manager_ctrl0_r.timebase_enable && tb_tick)
         timebase_r <= timebase_nxt;
   end

   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         timebase_upper <= '0;
         timebase_lower <= '0;
      end
      else
      begin
         timebase_upper <= timebase_r[`TB_WIDTH-1:`TB_LOWER_WIDTH];
         timebase_lower <= timebase_r[`TB_LOWER_WIDTH-1:0];
      end
   end

   // ------------------------------------------------------------
   // Flag output and user I/O line
   // ------------------------------------------------------------
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         external_flag_out <= 1'b0;
         external_flag_oe  <= 1'b0;
      end
      else
      begin
         external_flag_oe  <= clock_manager_ctrl0_r.timebase_enable;
         external_flag_out <= clock_manager_ctrl0_r.external_flag;
      end
   end

   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         user_io_out     <= 1'b0;
         user_io_oe      <= 1'b0;
         input_level_bit <= 1'b0;
         irq3_pulse      <= 1'b0;
      end
      else
      begin
         user_io_oe  <= long_interrupt_register_r.direction;
         user_io_out <= long_interrupt_register_r.output_level_bit;
         if (!long_interrupt_register_r.direction)
            input_level_bit <= io_level;
         irq3_pulse <= !long_interrupt_register_r.direction && io_rise &&
                       long_interrupt_register_r.edge_irq_enable;
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   property p_attention;
      @(posedge clock) disable iff (!nrst)
      outbox_write |=> !host_attention_n;
   endproperty
   a_attention: assert property (p_attention)
      else $error("Host attention not asserted after outbox write");

   property p_tb_hold;
      @(posedge clock) disable iff (!nrst)
      !clock_manager_ctrl0_r.timebase_enable |=> $stable(timebase_r);
   endproperty
   a_tb_hold: assert property (p_tb_hold)
      else $error("Timebase moved while disabled");

   property p_tb_step;
      @(posedge clock) disable iff (!nrst)
      (clock_manager_ctrl0_r.timebase_enable && tb_tick &&
       timebase_r != `TB_MAX) |=> timebase_r == $past(timebase_r) + 1;
   endproperty
   a_tb_step: assert property (p_tb_step)
      else $error("Timebase did not step by one");

   property p_flag;
      @(posedge clock) disable iff (!nrst)
      clock_manager_ctrl0_r.timebase_enable |=>
         external_flag_oe && external_flag_out ==
         $past(clock_manager_ctrl0_r.external_flag);
   endproperty
   a_flag: assert property (p_flag)
      else $error("Flag output wrong");

   property p_io_out;
      @(posedge clock) disable iff (!nrst)
      long_interrupt_register_r.direction |=> user_io_oe;
   endproperty
   a_io_out: assert property (p_io_out)
      else $error("User I/O not driven");

   property p_irq;
      @(posedge clock) disable iff (!nrst)
      irq3_pulse |-> $past(long_interrupt_register_r.edge_irq_enable) &&
                     !$past(long_interrupt_register_r.direction);
   endproperty
   a_irq: assert property (p_irq)
      else $error("Edge interrupt without enable");

   sequence s_start;
      state_r == pin_ctrl_pkg::st_reset && nrst;
   endsequence
   property p_wake;
      @(posedge clock) disable iff (!nrst)
      s_start |=> !dac_mute && dac_recalibrate && port_enable;
   endproperty
   a_wake: assert property (p_wake)
      else $error("No wake one cycle after reset");

   property p_ref;
      @(posedge clock) disable iff (!nrst)
      ref_tick |=> refdiv_r == 9'h000;
   endproperty
   a_ref: assert property (p_ref)
      else $error("Reference divider tick misplaced");

   property p_alt;
      @(posedge clock) disable iff (!nrst)
      !external_vco_select |=> !alt_clock_enable;
   endproperty
   a_alt: assert property (p_alt)
      else $error("Alternate clock not disabled");
endmodule : pin_timebase_control

// ==== host_model.sv ====
// Host controller model on the far side of the control port
`timescale 1ns/1ps
module host_model
(
   input  wire logic       clock,
   input  wire logic       nrst,
   input  wire logic       strap_level,
   input  wire logic       txn,
   input  wire logic [3:0] service_delay,
   input  wire logic       host_attention_n,
   output logic            chip_select_n,
   output logic            host_service_done
);
   logic       pending_r;
   logic [3:0] cnt_r;
   // ------
   // Chip select: strap level, low while a transaction runs
   // ------
   assign chip_select_n = txn ? 1'b0 : strap_level;
   // ------
   // Attention service after a programmable delay
   // ------
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         pending_r         <= 1'b0;
         cnt_r             <= 4'h0;
         host_service_done <= 1'b0;
      end
      else
      begin
         host_service_done <= 1'b0;
         if (!pending_r && !host_attention_n)
         begin
            pending_r <= 1'b1;
            cnt_r     <= service_delay;
         end
         else if (pending_r && host_attention_n)
            pending_r <= 1'b0;
         else if (pending_r && cnt_r != 4'h0)
            cnt_r <= cnt_r - 4'h1;
         else if (pending_r && !host_service_done)
            host_service_done <= 1'b1;
      end
   end
endmodule : host_model

// ==== pin_timebase_control_bench.sv ====
// Self-checking bench of the pin and timebase control block
`timescale 1ns/1ps
module pin_timebase_control_bench;
   pin_ctrl_pkg::clock_manager_ctrl0_t     cm0_wdata;
   pin_ctrl_pkg::long_interrupt_register_t long_interrupt_register_wdata;
   logic        clock, nrst, cm0_write, long_interrupt_register_write, outbox_write;
   logic        format_wdata, format_write, boot_pin, chip_select_n;
   logic        counter_clock_90k, reference_tick, external_vco_select;
   logic        user_io_in, user_io_out, user_io_oe, external_flag_out;
   logic        external_flag_oe, divided_clock_output, host_attention_n;
   logic        port_format_select, port_enable, alt_clock_enable;
   logic        dac_mute, dac_recalibrate, boot_loader_start;
   logic        input_level_bit, irq3_pulse, host_service_done;
   logic        strap_level, txn, ext_oe, ext_v, flag_wire;
   logic [3:0]  service_delay;
   logic [23:0] timebase_upper;
   logic [8:0]  timebase_lower;
   int          err_total, compares;
   // ------
   // Pin levels with pull-down and pull-up
   // ------
   assign user_io_in = user_io_oe ? user_io_out : (ext_oe ? ext_v : 1'b0);
   assign flag_wire  = external_flag_oe ? external_flag_out : 1'b1;
   pin_timebase_control dut_u
   (
      .clock, .nrst, .cm0_wdata, .cm0_write, .long_interrupt_register_wdata, .long_interrupt_register_write,
      .outbox_write, .host_service_done, .format_wdata, .format_write,
      .boot_pin, .chip_select_n, .counter_clock_90k, .reference_tick,
      .external_vco_select, .user_io_in, .user_io_out, .user_io_oe,
      .external_flag_out, .external_flag_oe, .divided_clock_output,
      .host_attention_n, .port_format_select, .port_enable,
      .alt_clock_enable, .dac_mute, .dac_recalibrate, .boot_loader_start,
      .input_level_bit, .irq3_pulse, .timebase_upper, .timebase_lower
   );
   host_model host_u
   (
      .clock, .nrst, .strap_level, .txn, .service_delay,
      .host_attention_n, .chip_select_n, .host_service_done
   );
   initial
   begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end
   // ------
   // Tasks
   // ------
   task complete_run;
      $display("compares %0d err_total %0d", compares, err_total);
      if (err_total == 0 && compares > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : complete_run
   task check(input string nm, input logic [32:0] seen, exp);
      compares++;
      if (seen !== exp)
      begin
         err_total++;
         $display("[FAIL] %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask : check
   task cyc(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask : cyc
   task automatic await(ref logic s, input logic v, input int lim,
                        input string nm);
      int i;
      for (i = 0; i < lim && s !== v; i++)
         cyc(1);
      check(nm, {32'h0, s}, {32'h0, v});
      if (s !== v)
         complete_run();
   endtask : await
   task strobe(input logic [3:0] s);
      {cm0_write, long_interrupt_register_write, outbox_write, format_write} <= s;
      @(posedge clock);
      {cm0_write, long_interrupt_register_write, outbox_write, format_write} <= 4'h0;
      cyc(1);
   endtask : strobe
   task wr_cm0(input logic te, sel, fl, input logic [9:0] q);
      @(posedge clock);
      cm0_wdata <= '{te, sel, fl, q};
      strobe(4'h8);
   endtask : wr_cm0
   task wr_long_interrupt_register(input logic dir, lvl, en);
      @(posedge clock);
      long_interrupt_register_wdata <= '{dir, lvl, en};
      strobe(4'h4);
   endtask : wr_long_interrupt_register
   task toggle_90k(input int n);
      repeat (n)
      begin
         @(posedge clock);
         counter_clock_90k <= 1'b1;
         cyc(4);
         @(posedge clock);
         counter_clock_90k <= 1'b0;
         cyc(4);
      end
      cyc(6);
   endtask : toggle_90k
   task period(input int q);
      int n;
      await(divided_clock_output, 1'b0, 2100, "divclk low");
      await(divided_clock_output, 1'b1, 2100, "divclk rise");
      n = 0;
      while (divided_clock_output === 1'b1 && n < 2100)
      begin
         cyc(1);
         n++;
      end
      check("divclk high cycles", n, q);
   endtask : period
   task do_reset(input logic b, s);
      @(posedge clock);
      nrst                <= 1'b0;
      boot_pin            <= b;
      strap_level         <= s;
      external_vco_select <= b;
      txn                 <= 1'b0;
      cyc(1);
      check("mute", dac_mute, 1'b1);
      check("attention", host_attention_n, 1'b1);
      check("cleared", {port_enable, alt_clock_enable, user_io_oe,
            external_flag_oe, port_format_select}, 5'h00);
      check("timebase", {timebase_upper, timebase_lower}, 33'h0);
      @(posedge clock);
      nrst <= 1'b1;
      await(dac_recalibrate, 1'b1, 2, "recalibrate");
      check("boot start", boot_loader_start, b);
      check("strap", port_format_select, s);
      check("run", {port_enable, dac_mute}, 2'h2);
      check("alt clock", alt_clock_enable, b);
      cyc(1);
      check("recal pulse", dac_recalibrate, 1'b0);
   endtask : do_reset
   // ------
   // Main sequence
   // ------
   initial
   begin
      nrst = 1'b0;
      cm0_wdata = '0;
      long_interrupt_register_wdata = '0;
      {cm0_write, long_interrupt_register_write, outbox_write, format_write} = 4'h0;
      {format_wdata, boot_pin, counter_clock_90k, reference_tick} = 4'h0;
      {external_vco_select, strap_level, txn, ext_oe, ext_v} = 5'h00;
      service_delay = 4'h0;
      err_total = 0;
      compares = 0;
      do_reset(1'b1, 1'b1);
      wr_cm0(1'b1, 1'b0, 1'b1, 10'h003);
      check("flag oe", external_flag_oe, 1'b1);
      check("flag wire", flag_wire, 1'b1);
      period(3);
      wr_cm0(1'b1, 1'b0, 1'b0, 10'h000);
      check("flag wire", flag_wire, 1'b0);
      period(2);
      wr_cm0(1'b1, 1'b0, 1'b0, 10'h001);
      period(2);
      check("timebase", {timebase_upper, timebase_lower}, 33'h0);
      toggle_90k(5);
      check("timebase 90k", {timebase_upper, timebase_lower}, 33'h5);
      wr_cm0(1'b1, 1'b1, 1'b0, 10'h000);
      repeat (600)
      begin
         @(posedge clock);
         reference_tick <= 1'b1;
         @(posedge clock);
         reference_tick <= 1'b0;
      end
      cyc(4);
      check("timebase ref", {timebase_upper, timebase_lower}, 33'h7);
      wr_cm0(1'b0, 1'b0, 1'b0, 10'h000);
      check("flag released", flag_wire, 1'b1);
      toggle_90k(3);
      check("timebase hold", {timebase_upper, timebase_lower}, 33'h7);
      wr_long_interrupt_register(1'b1, 1'b1, 1'b0);
      check("io oe", user_io_oe, 1'b1);
      check("io wire", user_io_in, 1'b1);
      wr_long_interrupt_register(1'b1, 1'b0, 1'b1);
      check("io wire", user_io_in, 1'b0);
      wr_long_interrupt_register(1'b0, 1'b0, 1'b1);
      check("io oe", user_io_oe, 1'b0);
      @(posedge clock);
      ext_oe <= 1'b1;
      ext_v  <= 1'b1;
      await(irq3_pulse, 1'b1, 6, "irq3");
      cyc(1);
      check("irq3 pulse", irq3_pulse, 1'b0);
      check("level bit", input_level_bit, 1'b1);
      @(posedge clock);
      ext_v <= 1'b0;
      cyc(4);
      check("level bit", input_level_bit, 1'b0);
      wr_long_interrupt_register(1'b0, 1'b0, 1'b0);
      @(posedge clock);
      ext_v <= 1'b1;
      repeat (8)
      begin
         cyc(1);
         check("irq3 masked", irq3_pulse, 1'b0);
      end
      for (int f = 0; f < 2; f++)
      begin
         @(posedge clock);
         format_wdata <= f[0];
         strobe(4'h1);
         check("format", port_format_select, f[0]);
      end
      for (int d = 0; d < 7; d += 6)
      begin
         @(posedge clock);
         service_delay <= d[3:0];
         txn           <= 1'b1;
         strobe(4'h2);
         check("attention", host_attention_n, 1'b0);
         await(host_attention_n, 1'b1, 20, "attention off");
         check("format kept", port_format_select, 1'b1);
      end
      do_reset(1'b0, 1'b0);
      complete_run();
   end
endmodule : pin_timebase_control_bench
